/* File: rtl/lpa_push_ctrl.v */
// push-mode acquisition, internal averaging and dataset streaming with apb registers
// Contract
// RULE1: each finished dataset is streamed out as soon as acquisition completes.
// RULE2: progress header is full size, zero except marker, shots and timestamp.
// RULE3: client uses a progress header only to update shots and timestamp.
// RULE4: fine/standard dual modes exist only when the fine resolution flag is reported.
// RULE5: standard mode accepts bin lengths from 10 ns in steps of 10.
// RULE6: largest standard bin length equals the reported longest bin parameter.
// RULE7: standard mode samples by resolution and bin count.
// RULE8: a resolution below 10 ns selects fine mode automatically.
// RULE9: fine mode always samples at the shortest reported bin length.
// RULE10: fine mode can output bins of two, four or eight shortest lengths.
// RULE11: merging reduces the maximum output bin count by the merge factor.
// RULE12: the maximum internally averaged shot count is reported.
// RULE13: beyond that limit the client streams and sums datasets itself.
// RULE14: client decompresses each dataset per channel before summing.
// RULE15: every dataset starts with a 32-byte header read first by the client.
// RULE16: client byte-swaps according to reported endianness.
// RULE17: client sizes payload from sample width, trace count and trace length.
// RULE18: client adds dataset Q to the sum of the previous Q-1.
// RULE19: client stops after enough datasets, else reads the next header.
// RULE20: client should set internal averaging to the maximum shot count.
// RULE21: header timestamp counts milliseconds since power-on.
// RULE22: a merged bin carries the sum of the merged photon counts.
`timescale 1ns/1ns
`include "lpa_consts.vh"

module lpa_push_ctrl #(
	parameter [31:0] MS_CYCLES = `LPA_CLK_HZ / `LPA_MS_PER_S
) (
	input wire sys_clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire trig_pin,
	input wire [15:0] fe_cnt,
	input wire fe_vld,
	output wire fe_arm,
	output wire fe_fine,
	output wire [15:0] fe_bin_len_ns,
	output wire [31:0] st_data,
	output wire st_valid,
	input wire st_ready,
	output wire st_last
);

localparam [5:0] S_IDLE = 6'h01;
localparam [5:0] S_ARM = 6'h02;
localparam [5:0] S_ACQ = 6'h04;
localparam [5:0] S_HDR = 6'h08;
localparam [5:0] S_DATA = 6'h10;
localparam [5:0] S_PROG = 6'h20;
// named copies so the capability fields can be part-selected
localparam [15:0] SHORTEST_BIN = `LPA_SHORTEST_BIN;
localparam [31:0] MAX_SHOTS = `LPA_MAX_SHOTS;

reg [5:0] state_r;
reg [5:0] state_nxt;
reg prog_en_r;
reg [15:0] res_r;
reg [8:0] bins_r;
reg [31:0] shots_tgt_r;
reg err_r;
reg fine_r;
reg [1:0] sh_r;
reg [31:0] shots_r;
reg [31:0] hdr_shots_r;
reg [31:0] hdr_ts_r;
reg [8:0] bin_idx_r;
reg [8:0] word_idx_r;
reg [31:0] st_data_r;
reg st_valid_r;
reg st_last_r;
reg [31:0] prdata_r;
reg trig_s1_r;
reg trig_s2_r;
reg trig_s3_r;
reg [31:0] acc_mem [0:(1 << `LPA_MEM_AW) - 1];

wire [31:0] ms_cnt;
wire [31:0] mrg_sum;
wire mrg_vld;
wire trig_rise;
wire wr_en;
wire rd_setup;
wire addr_ok;
wire run_wr;
wire stop_wr;
wire start_ok;
wire cfg_fine;
wire fine_ok;
wire std_ok;
wire [1:0] cfg_sh;
wire [8:0] max_bins;
wire cfg_ok;
wire load;
wire shot_done;
wire [8:0] data_words;
wire [15:0] out_bin_len;

lpa_ms_timer #(
	.MS_CYCLES(MS_CYCLES)
) u_timer (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.ms_cnt(ms_cnt)
);

lpa_bin_merge u_merge (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.clr(trig_rise),
	.shift(sh_r),
	.in_cnt(fe_cnt),
	.in_vld(fe_vld && (state_r == S_ACQ)),
	.out_sum(mrg_sum),
	.out_vld(mrg_vld)
);

// trigger arrives from a pin, so two flops before anything looks at it
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		trig_s1_r <= 1'b0;
		trig_s2_r <= 1'b0;
		trig_s3_r <= 1'b0;
	end else begin
		trig_s1_r <= trig_pin;
		trig_s2_r <= trig_s1_r;
		trig_s3_r <= trig_s2_r;
	end
end

assign trig_rise = trig_s2_r && !trig_s3_r && (state_r == S_ARM);

// resolution decode: below the standard step the block goes fine by itself
assign cfg_fine = res_r < `LPA_STD_STEP_NS; // RULE8
assign cfg_sh = (res_r == (`LPA_SHORTEST_BIN << 1)) ? 2'h1 :
	(res_r == (`LPA_SHORTEST_BIN << 2)) ? 2'h2 :
	(res_r == (`LPA_SHORTEST_BIN << 3)) ? 2'h3 : 2'h0;
assign fine_ok = `LPA_HAS_FINE && ((res_r == `LPA_SHORTEST_BIN) || (cfg_sh != 2'h0)); // RULE4 RULE10
assign std_ok = (res_r % `LPA_STD_STEP_NS == 16'h0000) && (res_r <= `LPA_LONGEST_BIN); // RULE5 RULE6
assign max_bins = `LPA_RAW_BINS >> (cfg_fine ? cfg_sh : 2'h0); // RULE11
assign cfg_ok = (cfg_fine ? fine_ok : std_ok) && (bins_r != 9'h000) && (bins_r <= max_bins) &&
	(shots_tgt_r != 32'h00000000) && (shots_tgt_r <= `LPA_MAX_SHOTS);

// apb: zero wait states, read data captured in the setup cycle
assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `LPA_A_TIME);
assign wr_en = psel && penable && pwrite && addr_ok;
assign rd_setup = psel && !penable && !pwrite;
assign pready = 1'b1;
assign pslverr = psel && penable && !addr_ok;
assign prdata = prdata_r;
assign run_wr = wr_en && (paddr == `LPA_A_CTRL) && pwdata[`LPA_CTRL_RUN];
assign stop_wr = wr_en && (paddr == `LPA_A_CTRL) && !pwdata[`LPA_CTRL_RUN];
assign start_ok = run_wr && (state_r == S_IDLE) && cfg_ok;

always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		prdata_r <= 32'h00000000;
	end else if (rd_setup) begin
		case (paddr)
		`LPA_A_CTRL: prdata_r <= {30'h00000000, prog_en_r, state_r != S_IDLE};
		`LPA_A_RES: prdata_r <= {16'h0000, res_r};
		`LPA_A_BINS: prdata_r <= {23'h000000, bins_r};
		`LPA_A_SHOTS: prdata_r <= shots_tgt_r;
		`LPA_A_STATUS: prdata_r <= {shots_r[15:0], 13'h0000, fine_r, err_r, state_r != S_IDLE};
		`LPA_A_HW_BIN: prdata_r <= {`LPA_HAS_FINE, SHORTEST_BIN[14:0], `LPA_LONGEST_BIN}; // RULE4 RULE6
		`LPA_A_HW_SHOTS: prdata_r <= {`LPA_SAMPLE_WIDTH, MAX_SHOTS[23:0]}; // RULE12
		`LPA_A_TIME: prdata_r <= ms_cnt;
		default: prdata_r <= 32'h00000000;
		endcase
	end
end

// configuration is frozen while running so a dataset never mixes settings
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		prog_en_r <= 1'b0;
		res_r <= `LPA_RES_RST;
		bins_r <= `LPA_BINS_RST;
		shots_tgt_r <= `LPA_SHOTS_RST;
		err_r <= 1'b0;
		fine_r <= 1'b0;
		sh_r <= 2'h0;
	end else begin
		if (wr_en && (paddr == `LPA_A_CTRL)) begin
			prog_en_r <= pwdata[`LPA_CTRL_PROG];
		end
		if (wr_en && (state_r == S_IDLE)) begin
			if (paddr == `LPA_A_RES) begin
				res_r <= pwdata[15:0];
			end
			if (paddr == `LPA_A_BINS) begin
				bins_r <= pwdata[8:0];
			end
			if (paddr == `LPA_A_SHOTS) begin
				shots_tgt_r <= pwdata;
			end
		end
		// a refused start sets the error flag; the set wins over a clear
		if (run_wr && (state_r == S_IDLE) && !cfg_ok) begin
			err_r <= 1'b1;
		end else if (wr_en && (paddr == `LPA_A_STATUS) && pwdata[`LPA_ST_ERR]) begin
			err_r <= 1'b0;
		end
		if (start_ok) begin
			fine_r <= cfg_fine;
			sh_r <= cfg_fine ? cfg_sh : 2'h0;
		end
	end
end

// front end: fine mode always runs at the shortest bin, standard at the setting
assign fe_fine = fine_r;
assign fe_bin_len_ns = fine_r ? `LPA_SHORTEST_BIN : res_r; // RULE7 RULE9
assign fe_arm = (state_r == S_ACQ);
assign out_bin_len = fine_r ? (`LPA_SHORTEST_BIN << sh_r) : res_r;

assign shot_done = mrg_vld && (state_r == S_ACQ) && (bin_idx_r == bins_r - 9'h001); // RULE7
assign load = !st_valid_r || st_ready;
assign data_words = (state_r == S_DATA) ? bins_r : `LPA_HDR_WORDS;

// header words; a progress header leaves every other field zero
function [31:0] hdr_word;
	input [8:0] idx;
	input prog;
	begin
		case (idx)
		9'h000: hdr_word = `LPA_MARKER;
		9'h001: hdr_word = hdr_shots_r;
		9'h002: hdr_word = hdr_ts_r; // RULE21
		9'h003: hdr_word = prog ? 32'h00000000 : {23'h000000, bins_r};
		9'h004: hdr_word = prog ? 32'h00000000 : `LPA_TRACES;
		9'h005: hdr_word = prog ? 32'h00000000 : {16'h0000, out_bin_len};
		9'h006: hdr_word = prog ? 32'h00000000 : {29'h00000000, fine_r, sh_r};
		default: hdr_word = 32'h00000000;
		endcase
	end
endfunction

always @* begin
	state_nxt = state_r;
	case (state_r)
	S_IDLE: begin
		if (start_ok) begin
			state_nxt = S_ARM;
		end
	end
	S_ARM: begin
		if (trig_rise) begin
			state_nxt = S_ACQ;
		end
	end
	S_ACQ: begin
		if (shot_done) begin
			if (shots_r + 32'h00000001 == shots_tgt_r) begin
				state_nxt = S_HDR; // RULE1
			end else if (prog_en_r) begin
				state_nxt = S_PROG;
			end else begin
				state_nxt = S_ARM;
			end
		end
	end
	S_HDR: begin
		if (load && (word_idx_r == data_words)) begin
			state_nxt = S_DATA; // RULE15
		end
	end
	S_DATA: begin
		if (load && (word_idx_r == data_words)) begin
			state_nxt = S_ARM;
		end
	end
	S_PROG: begin
		if (load && (word_idx_r == data_words)) begin
			state_nxt = S_ARM;
		end
	end
	default: state_nxt = S_IDLE;
	endcase
	if (stop_wr) begin
		state_nxt = S_IDLE;
	end
end

always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		state_r <= S_IDLE;
		shots_r <= 32'h00000000;
		hdr_shots_r <= 32'h00000000;
		hdr_ts_r <= 32'h00000000;
		bin_idx_r <= 9'h000;
		word_idx_r <= 9'h000;
	end else begin
		state_r <= state_nxt;
		if (trig_rise) begin
			bin_idx_r <= 9'h000;
		end else if (mrg_vld && (state_r == S_ACQ)) begin
			bin_idx_r <= bin_idx_r + 9'h001;
		end
		if (state_nxt != state_r) begin
			word_idx_r <= 9'h000;
		end else if (load && (state_r == S_HDR || state_r == S_DATA || state_r == S_PROG)) begin
			word_idx_r <= word_idx_r + 9'h001;
		end
		if (start_ok || stop_wr) begin
			shots_r <= 32'h00000000;
		end else if (shot_done) begin
			// the count restarts once a full dataset is framed
			shots_r <= (state_nxt == S_HDR) ? 32'h00000000 : shots_r + 32'h00000001;
			hdr_shots_r <= shots_r + 32'h00000001; // RULE2
			hdr_ts_r <= ms_cnt; // RULE21
		end
	end
end

// averaging memory: the first shot of a dataset overwrites, later shots add
always @(posedge sys_clk) begin
	if (mrg_vld && (state_r == S_ACQ)) begin
		acc_mem[bin_idx_r[`LPA_MEM_AW - 1:0]] <= (shots_r == 32'h00000000) ? mrg_sum :
			acc_mem[bin_idx_r[`LPA_MEM_AW - 1:0]] + mrg_sum;
	end
end

// stream output; the sink may stall at any word via st_ready
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		st_data_r <= 32'h00000000;
		st_valid_r <= 1'b0;
		st_last_r <= 1'b0;
	end else if (stop_wr) begin
		st_valid_r <= 1'b0;
		st_last_r <= 1'b0;
	end else if (load) begin
		st_valid_r <= 1'b0;
		st_last_r <= 1'b0;
		if (word_idx_r != data_words) begin
			if (state_r == S_HDR || state_r == S_PROG) begin
				st_data_r <= hdr_word(word_idx_r, state_r == S_PROG); // RULE2 RULE15
				st_valid_r <= 1'b1;
				st_last_r <= (state_r == S_PROG) && (word_idx_r == data_words - 9'h001);
			end else if (state_r == S_DATA) begin
				st_data_r <= acc_mem[word_idx_r[`LPA_MEM_AW - 1:0]]; // RULE1
				st_valid_r <= 1'b1;
				st_last_r <= (word_idx_r == data_words - 9'h001);
			end
		end
	end
end

assign st_data = st_data_r;
assign st_valid = st_valid_r;
assign st_last = st_last_r;

endmodule // lpa_push_ctrl

/* File: rtl/lpa_consts.vh */
// constants shared by the lidar push acquisition control block
`ifndef LPA_CONSTS_VH
`define LPA_CONSTS_VH

`define LPA_CLK_HZ 50000000
`define LPA_MS_PER_S 1000

// apb register byte offsets
`define LPA_A_CTRL 8'h00
`define LPA_A_RES 8'h04
`define LPA_A_BINS 8'h08
`define LPA_A_SHOTS 8'h0c
`define LPA_A_STATUS 8'h10
`define LPA_A_HW_BIN 8'h14
`define LPA_A_HW_SHOTS 8'h18
`define LPA_A_TIME 8'h1c

// control and status bit positions
`define LPA_CTRL_RUN 0
`define LPA_CTRL_PROG 1
`define LPA_ST_RUN 0
`define LPA_ST_ERR 1
`define LPA_ST_FINE 2

// reset values
`define LPA_RES_RST 16'h000a
`define LPA_BINS_RST 9'h100
`define LPA_SHOTS_RST 32'h00000001

// hardware capabilities; all but the standard step are reported in the hardware-information registers
`define LPA_HAS_FINE 1'b1
`define LPA_STD_STEP_NS 16'h000a
`define LPA_LONGEST_BIN 16'h03e8
`define LPA_SHORTEST_BIN 16'h0001
`define LPA_MAX_SHOTS 32'h00001000
`define LPA_SAMPLE_WIDTH 8'h04

// acquisition memory and dataset framing
`define LPA_MEM_AW 8
`define LPA_RAW_BINS 9'h100
`define LPA_HDR_WORDS 9'h008
`define LPA_MARKER 32'h0000a5a5
`define LPA_TRACES 32'h00000001

`endif

/* File: rtl/lpa_ms_timer.v */
// millisecond timestamp counter running from power-on reset
`timescale 1ns/1ns
`include "lpa_consts.vh"

module lpa_ms_timer #(
	parameter [31:0] MS_CYCLES = `LPA_CLK_HZ / `LPA_MS_PER_S
) (
	input wire sys_clk,
	input wire nrst,
	output wire [31:0] ms_cnt
);

reg [31:0] cyc_r;
reg [31:0] ms_r;

always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		cyc_r <= 32'h00000000;
		ms_r <= 32'h00000000;
	end else if (cyc_r == MS_CYCLES - 32'h00000001) begin
		cyc_r <= 32'h00000000;
		ms_r <= ms_r + 32'h00000001; // RULE21
	end else begin
		cyc_r <= cyc_r + 32'h00000001;
	end
end

assign ms_cnt = ms_r;

endmodule // lpa_ms_timer

/* File: rtl/lpa_bin_merge.v */
// sums 1, 2, 4 or 8 adjacent fine bins into one output bin
`timescale 1ns/1ns

module lpa_bin_merge (
	input wire sys_clk,
	input wire nrst,
	input wire clr,
	input wire [1:0] shift,
	input wire [15:0] in_cnt,
	input wire in_vld,
	output wire [31:0] out_sum,
	output wire out_vld
);

reg [2:0] phase_r;
reg [31:0] acc_r;
reg [31:0] sum_r;
reg vld_r;
wire [2:0] last;

assign last = (3'h1 << shift) - 3'h1;

always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		phase_r <= 3'h0;
		acc_r <= 32'h00000000;
		sum_r <= 32'h00000000;
		vld_r <= 1'b0;
	end else if (clr) begin
		// a new trace must not inherit a partial group from the last one
		phase_r <= 3'h0;
		acc_r <= 32'h00000000;
		vld_r <= 1'b0;
	end else begin
		vld_r <= 1'b0;
		if (in_vld) begin
			if (phase_r == last) begin
				sum_r <= acc_r + {16'h0000, in_cnt}; // RULE22
				vld_r <= 1'b1; // RULE10
				acc_r <= 32'h00000000;
				phase_r <= 3'h0;
			end else begin
				acc_r <= acc_r + {16'h0000, in_cnt};
				phase_r <= phase_r + 3'h1;
			end
		end
	end
end

assign out_sum = sum_r;
assign out_vld = vld_r;

endmodule // lpa_bin_merge

/* File: sim/lpa_push_checker.sv */
// assertion checker on the push acquisition control ports
`timescale 1ns/1ns
`include "lpa_consts.vh"
module lpa_push_checker (
	input wire sys_clk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire trig_pin,
	input wire fe_arm,
	input wire fe_fine,
	input wire [15:0] fe_bin_len_ns,
	input wire [31:0] st_data,
	input wire st_valid,
	input wire st_ready,
	input wire st_last
);
	default clocking dck @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	wire acc = st_valid && st_ready;
	wire wr = psel && penable && pwrite;
	wire bad = paddr > `LPA_A_TIME || paddr[1:0] != 2'h0;
	reg [3:0] wcnt_r;
	// a stop write abandons the stream, so the word count restarts there too
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			wcnt_r <= 4'h0;
		else if ((acc && st_last) || (wr && paddr == `LPA_A_CTRL))
			wcnt_r <= 4'h0;
		else if (acc && wcnt_r < 4'h8)
			wcnt_r <= wcnt_r + 4'h1;
	end
	AST_APB_READY: assert property (psel && penable |-> pready)
		else $error("access without ready");
	AST_UNMAPPED: assert property (psel && penable && bad |-> pslverr)
		else $error("unmapped access not flagged");
	AST_MAPPED: assert property (psel && penable && !bad |-> !pslverr)
		else $error("mapped access flagged");
	AST_HOLD: assert property (st_valid && !st_ready && !wr |=> st_valid && $stable(st_data) && $stable(st_last))
		else $error("stream word dropped before acceptance");
	AST_MARKER: assert property (acc && wcnt_r == 4'h0 |-> st_data == `LPA_MARKER)
		else $error("header does not open with marker");
	AST_GAP: assert property (acc && wcnt_r == 4'h7 && !st_last |=> !st_valid)
		else $error("no gap after header");
	AST_FINE_LEN: assert property (fe_arm && fe_fine |-> fe_bin_len_ns == `LPA_SHORTEST_BIN)
		else $error("fine mode not at shortest bin");
	AST_STD_LEN: assert property (fe_arm && !fe_fine |-> fe_bin_len_ns >= 16'h000a && fe_bin_len_ns % 16'h000a == 16'h0000
		&& fe_bin_len_ns <= `LPA_LONGEST_BIN)
		else $error("standard bin length out of range");
	// the first sync flop takes the pin three edges before the rise of fe_arm is seen
	AST_ARM_TRIG: assert property ($rose(fe_arm) |-> $past(trig_pin, 3))
		else $error("capture without trigger");
	AST_QUIET: assert property (fe_arm |-> !st_valid)
		else $error("streaming during capture");
endmodule // lpa_push_checker

/* File: sim/lpa_client_model.sv */
// stream sink standing in for the client application
`timescale 1ns/1ns
`include "lpa_consts.vh"
module lpa_client_model (
	input wire sys_clk,
	input wire nrst,
	input wire slow,
	input wire [31:0] st_data,
	input wire st_valid,
	input wire st_last,
	output reg st_ready
);
	logic [31:0] got[$];
	logic [31:0] hdr[0:7];
	logic [31:0] sum[0:255];
	int w = 0;
	int n_sets = 0;
	int n_badlast = 0;
	int shots_seen = 0;
	int ts_seen = 0;
	reg [2:0] ph_r;
	// header first, then a payload sized from it; words 3..7 all zero mark a progress-only header
	task automatic take(input logic [31:0] d, input logic lst);
		logic fin;
		fin = 1'b0;
		if (w < 8) begin
			hdr[w] = d;
			if (w == 7 && hdr[3] == 0 && hdr[4] == 0 && hdr[5] == 0 && hdr[6] == 0 && d == 0) begin
				shots_seen = hdr[1];
				ts_seen = hdr[2];
				fin = 1'b1;
			end
		end else begin
			// one whole 32-bit sample of the single trace per word: nothing to unpack, no byte swap
			sum[w - 8] = (n_sets == 0) ? d : sum[w - 8] + d;
			if (w - 7 == hdr[4] * hdr[3] * `LPA_SAMPLE_WIDTH / 32'h4) begin
				shots_seen = hdr[1];
				ts_seen = hdr[2];
				n_sets++;
				fin = 1'b1;
			end
		end
		if (lst !== fin)
			n_badlast++;
		w = fin ? 0 : w + 1;
	endtask
	// the header is taken first, in order, before any trace word
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_ready <= 1'b0;
			ph_r <= 3'h0;
		end else begin
			ph_r <= ph_r + 3'h1;
			st_ready <= !slow || ph_r[1];
			if (st_valid && st_ready) begin
				got.push_back(st_data);
				take(st_data, st_last);
			end
		end
	end
endmodule // lpa_client_model

/* File: sim/test_lidar_push_acquisition_control.sv */
// self-checking bench for the push acquisition control block
`timescale 1ns/1ns
`include "lpa_consts.vh"
module test_lidar_push_acquisition_control;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic trig_pin = 1'b0;
	logic [15:0] fe_cnt = 16'h0;
	logic fe_vld = 1'b0;
	logic slow = 1'b0;
	wire [31:0] prdata;
	wire [31:0] st_data;
	wire [15:0] fe_bin_len_ns;
	wire pready, pslverr, fe_arm, fe_fine, st_valid, st_ready, st_last;
	logic [31:0] q;
	logic err;
	int n_fail = 0;
	int n_tests = 0;
	always #10 sys_clk = ~sys_clk;
	lpa_push_ctrl #(.MS_CYCLES(32'd10)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trig_pin(trig_pin), .fe_cnt(fe_cnt), .fe_vld(fe_vld), .fe_arm(fe_arm), .fe_fine(fe_fine),
		.fe_bin_len_ns(fe_bin_len_ns), .st_data(st_data), .st_valid(st_valid), .st_ready(st_ready),
		.st_last(st_last));
	lpa_client_model i_cli (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .st_data(st_data),
		.st_valid(st_valid), .st_last(st_last), .st_ready(st_ready));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// the slave sets the pace; only the watchdog ends a hung access
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic shot(input int n, input logic [15:0] base);
		trig_pin <= 1'b1;
		while (fe_arm !== 1'b1) begin
			@(posedge sys_clk);
		end
		trig_pin <= 1'b0;
		for (int i = 0; i < n; i++) begin
			fe_cnt <= base + i[15:0];
			fe_vld <= 1'b1;
			@(posedge sys_clk);
			fe_vld <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	task automatic wait_words(input int n);
		int k;
		k = 0;
		while (i_cli.got.size() < n && k < 3000) begin
			@(posedge sys_clk);
			k++;
		end
		chk("word count", n, i_cli.got.size());
	endtask
	task automatic t_caps;
		apb(0, `LPA_A_HW_BIN, 0);
		chk("hw bin", 32'h800103e8, q);
		apb(0, `LPA_A_HW_SHOTS, 0);
		chk("hw shots", 32'h04001000, q);
		apb(1, `LPA_A_SHOTS, {8'h00, q[23:0]});
		apb(1, `LPA_A_CTRL, 32'h1);
		apb(0, `LPA_A_STATUS, 0);
		chk("max shots start", 32'h1, q & 32'h3);
		apb(1, `LPA_A_CTRL, 32'h0);
		apb(0, `LPA_A_RES, 0);
		chk("res reset", 32'h0000000a, q);
		apb(1, 8'h22, 32'h5);
		chk("unmapped err", 1, err);
		$display("test caps done");
	endtask
	task automatic t_cfg;
		logic [31:0] r[5] = '{15, 1010, 3, 8, 1000};
		logic [31:0] b[5] = '{2, 2, 2, 33, 1};
		logic [31:0] x[5] = '{2, 2, 2, 2, 1};
		for (int i = 0; i < 5; i++) begin
			apb(1, `LPA_A_RES, r[i]);
			apb(1, `LPA_A_BINS, b[i]);
			apb(1, `LPA_A_CTRL, 32'h1);
			apb(0, `LPA_A_STATUS, 0);
			chk("cfg status", x[i], q & 32'h3);
			apb(1, `LPA_A_CTRL, 32'h0);
			apb(1, `LPA_A_STATUS, 32'h2);
			apb(0, `LPA_A_STATUS, 0);
			chk("err clear", 0, q & 32'h2);
		end
		$display("test cfg done");
	endtask
	task automatic t_std;
		slow <= 1'b1;
		i_cli.got.delete();
		apb(1, `LPA_A_RES, 32'd20);
		apb(1, `LPA_A_BINS, 32'd3);
		apb(1, `LPA_A_SHOTS, 32'd2);
		apb(1, `LPA_A_CTRL, 32'h3);
		chk("std len", 20, fe_bin_len_ns);
		shot(3, 16'h10);
		wait_words(8);
		chk("progress shots", 1, i_cli.got[1]);
		chk("client shots", 32'h1, i_cli.shots_seen);
		chk("client sets", 32'h0, i_cli.n_sets);
		for (int i = 3; i < 8; i++)
			chk("progress zero", 0, i_cli.got[i]);
		shot(3, 16'h20);
		wait_words(19);
		chk("shots", 2, i_cli.got[9]);
		chk("bins", 3, i_cli.got[11]);
		chk("bin ns", 20, i_cli.got[13]);
		chk("stamp order", 1, i_cli.got[10] >= i_cli.got[2]);
		for (int i = 0; i < 3; i++)
			chk("sum", 32'h30 + 2 * i, i_cli.got[16 + i]);
		chk("client sets", 32'h1, i_cli.n_sets);
		// a second dataset of the same shots: the client sum must double
		shot(3, 16'h10);
		wait_words(27);
		shot(3, 16'h20);
		wait_words(38);
		chk("stamp step", 1, i_cli.got[29] > i_cli.got[10]);
		for (int i = 0; i < 3; i++)
			chk("client sum", 32'h60 + 4 * i, i_cli.sum[i]);
		chk("client sets", 32'h2, i_cli.n_sets);
		chk("client shots", 32'h2, i_cli.shots_seen);
		chk("last flag", 32'h0, i_cli.n_badlast);
		apb(1, `LPA_A_CTRL, 32'h0);
		slow <= 1'b0;
		$display("test std done");
	endtask
	task automatic t_fine;
		int m;
		for (int s = 0; s < 4; s++) begin
			m = 1 << s;
			i_cli.got.delete();
			apb(1, `LPA_A_RES, m);
			apb(1, `LPA_A_BINS, 32'd2);
			apb(1, `LPA_A_SHOTS, 32'd1);
			apb(1, `LPA_A_CTRL, 32'h1);
			chk("fine sel", 1, fe_fine);
			chk("fine len", 1, fe_bin_len_ns);
			shot(2 * m, 16'h1);
			wait_words(10);
			chk("out len", m, i_cli.got[5]);
			chk("mode", 4 + s, i_cli.got[6]);
			for (int j = 0; j < 2; j++)
				chk("merged", (j * m + 1) * m + m * (m - 1) / 2, i_cli.got[8 + j]);
			apb(1, `LPA_A_CTRL, 32'h0);
		end
		$display("test fine done");
	endtask
	task automatic t_time;
		logic [31:0] e;
		apb(0, `LPA_A_TIME, 0);
		e = q;
		repeat (100) @(posedge sys_clk);
		apb(0, `LPA_A_TIME, 0);
		chk("ms step", 1, (q - e) >= 9 && (q - e) <= 11);
		$display("test time done");
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_caps;
		t_cfg;
		t_std;
		t_fine;
		t_time;
		tally_and_finish;
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_fail++;
		$display("watchdog expired");
		tally_and_finish;
	end
endmodule // test_lidar_push_acquisition_control
bind lpa_push_ctrl lpa_push_checker i_chk (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin), .fe_arm(fe_arm),
	.fe_fine(fe_fine), .fe_bin_len_ns(fe_bin_len_ns), .st_data(st_data), .st_valid(st_valid),
	.st_ready(st_ready), .st_last(st_last));
